// ---- bench/nor_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module nor_dev_model
  import nor_port_pkg::*;
#(
  parameter logic [7:0] ID_CODE = 8'h5A  // Arbitrary value
) (
  // Pins from the host
  input wire flash_pins_t pins,
  input wire logic [15:0] host_q,
  // Towards the host
  output logic [15:0] dq,
  output logic ready
);
  logic [15:0] mem [int];
  logic [15:0] w;
  logic ident = 0;
  logic armed = 0;
  logic junk = 0;
  time t_sel = 0;
  initial ready = 1;
  // Released lines toggle so a stale value never passes for data
  always #7 junk = ~junk;
  always @(negedge pins.ce_n) t_sel = $time;
  always @(negedge pins.rst_n) begin
    ident = 0;
    armed = 0;
  end
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && pins.rst_n) begin
      if (armed) begin
        if (pins.wp_n || pins.addr < 21'h1FE000) begin
          mem[pins.addr] = host_q;
          ready = 0;
          ready <= #200 1'b1;
        end
        armed = 0;
      end else begin
        armed = host_q[7:0] == 8'hA0;
        if (host_q[7:0] == 8'h90) ident = 1;
        if (host_q[7:0] == 8'hF0) ident = 0;
      end
    end
  end
  always @(pins, ident, junk) begin
    w = mem.exists(pins.addr) ? mem[pins.addr] : 16'hFFFF;
    if (ident) w = {8'h00, ID_CODE};
    dq = {16{junk}};
    if (pins.rst_n && !pins.ce_n && !pins.oe_n && pins.we_n &&
        $time - t_sel >= 70) begin
      dq = pins.wide ? w : {{8{junk}}, pins.byte_lsb ? w[15:8] : w[7:0]};
    end
  end
endmodule
`default_nettype wire

// ---- bench/nor_host_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "nor_port_map.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  error_cnt++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module nor_host_tb
  import nor_port_pkg::*;
;
  localparam logic [7:0] ID = 8'h5A;
  logic ref_clk = 0;
  logic sys_rst = 1;
  logic ready;
  sw_req_t sw = '0;
  logic [31:0] rd_data, s;
  flash_pins_t pins;
  logic [15:0] data_in, data_out, data_oe_n, dq;
  logic [7:0] mode = 8'h04;
  logic [15:0] mem_exp [int];
  int error_cnt = 0;
  int checks_done = 0;
  always #5 ref_clk = ~ref_clk;
  // Each line carries the host where it drives, else the device
  assign data_in = (data_out & ~data_oe_n) | (dq & data_oe_n);
  nor_host u_nor_host (.ref_clk(ref_clk), .sys_rst(sys_rst), .sw(sw),
    .rd_data(rd_data), .pins(pins), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .op_complete_flag(ready));
  nor_dev_model #(.ID_CODE(ID)) u_nor_dev_model (.pins(pins),
    .host_q(data_out), .dq(dq), .ready(ready));
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    sw <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    sw <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    sw <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    sw <= '0;
    #1 d = rd_data;
  endtask
  task automatic op(input logic [7:0] go, input logic [21:0] a,
      input logic [15:0] d);
    int n;
    wr(`REG_ADDR, {10'h0, a});
    wr(`REG_WDATA, {16'h0, d});
    wr(`REG_CTRL, {24'h0, mode | go});
    n = 0;
    do begin
      rd(`REG_STATUS, s);
      n++;
    end while (s[0] !== 1'b0 && n < 200);
    if (n >= 200) error_cnt++;
  endtask
  task automatic prog(input logic [21:0] a, input logic [15:0] d);
    op(8'h02, a, 16'h00A0);
    op(8'h02, a, d);
    // Top boot sectors refuse programs while protected
    if (!mode[5] || a[21:1] < 21'h1FE000) mem_exp[a[21:1]] = d;
  endtask
  function automatic logic [15:0] ex(input logic [21:0] a);
    logic [15:0] w;
    w = mem_exp.exists(a[21:1]) ? mem_exp[a[21:1]] : 16'hFFFF;
    return mode[2] ? w : {8'h00, a[0] ? w[15:8] : w[7:0]};
  endfunction
  task automatic rdchk(input logic [21:0] a);
    op(8'h01, a, 16'h0);
    rd(`REG_RDATA, s);
    `CHK("rdata", ex(a), mode[2] ? s[15:0] : {8'h00, s[7:0]})
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #200us;
    error_cnt++;
    stop_test();
  end
  initial begin
    logic [21:0] a [4];
    void'($urandom(32'h3c2b));
    repeat (12) @(posedge ref_clk);
    sys_rst <= 0;
    rd(`REG_CTRL, s);
    `CHK("ctrl", 32'h4, s)
    rd(4'hF, s);
    `CHK("unmapped", 32'h0, s)
    foreach (a[i]) a[i] = 22'($urandom) & 22'h3FFFFE;
    rdchk(a[0]);
    $display("test reset done");
    mode = 8'h14;
    prog(a[0], 16'($urandom));
    repeat (40) @(posedge ref_clk);
    rd(`REG_STATUS, s);
    `CHK("busy_seen", 2'b11, s[2:1])
    rdchk(a[0]);
    mode = 8'h04;
    foreach (a[i]) prog(a[i], 16'($urandom));
    foreach (a[i]) rdchk(a[i]);
    $display("test program done");
    mode = 8'h00;
    rdchk(a[1]);
    rdchk(a[1] | 22'h1);
    mode = 8'h24;
    prog(22'h3FFFFE, 16'h1234);
    rdchk(22'h3FFFFE);
    $display("test byte and protect done");
    mode = 8'h04;
    op(8'h02, 22'h0, 16'h0090);
    op(8'h01, 22'h0, 16'h0);
    rd(`REG_RDATA, s);
    `CHK("ident", ID, s[7:0])
    op(8'h08, 22'h0, 16'h0);
    repeat (60) @(posedge ref_clk);
    rdchk(a[0]);
    $display("test ident and reset done");
    stop_test();
  end
endmodule
`default_nettype wire

// ---- common/nor_port_map.svh ----
`ifndef NOR_PORT_MAP_SVH
`define NOR_PORT_MAP_SVH

// Software register offsets
`define REG_ADDR 4'h0
`define REG_WDATA 4'h1
`define REG_CTRL 4'h2
`define REG_STATUS 4'h3
`define REG_RDATA 4'h4
// Control fields
`define CTRL_GO_READ 0
`define CTRL_GO_WRITE 1
`define CTRL_WIDE 2
`define CTRL_FLASH_RST 3
`define CTRL_ACCEL 4
`define CTRL_WP 5
// Timing in ns and cycles at 10 ns
`define CLK_NS 10
`define ACCESS_NS 70
`define ACCESS_CYC ((`ACCESS_NS + `CLK_NS - 1) / `CLK_NS)
`define WRITE_PULSE_NS 35
`define WRITE_PULSE_CYC ((`WRITE_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define SETUP_CYC 1
`define RESET_PULSE_NS 500
`define RESET_PULSE_CYC ((`RESET_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define RESET_REC_NS 50
`define RESET_REC_CYC ((`RESET_REC_NS + `CLK_NS - 1) / `CLK_NS)
`define CTRL_RESET 8'h04
`endif

// ---- common/nor_port_pkg.sv ----
package nor_port_pkg;
  typedef enum {ST_IDLE, ST_RD_SETUP, ST_RD_WAIT, ST_WR_SETUP, ST_WR_PULSE,
    ST_WR_HOLD, ST_RST_PULSE, ST_RST_REC} phase_t;
  typedef struct packed {
    logic [20:0] addr;
    logic byte_lsb;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic rst_n;
    logic wide;
    logic wp_n;
    logic accel;
  } flash_pins_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sw_req_t;
endpackage

// ---- design/nor_host.sv ----
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "nor_port_map.svh"
module nor_host
  import nor_port_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Software port
  input wire sw_req_t sw,
  output logic [31:0] rd_data,
  // Flash control pins
  output flash_pins_t pins,
  // Flash data lines, three-signal form
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic [15:0] data_oe_n,
  // Ready/busy from the flash
  input wire logic op_complete_flag
);
  typedef struct packed {
    phase_t phase;
    logic [7:0] ctrl;
    logic [21:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [7:0] cnt;
    logic busy_seen;
    logic [31:0] rd_data;
    flash_pins_t pins;
    logic drive;
  } state_t;

  state_t st, next_st;
  logic [16:0] sync_v;
  logic [15:0] data_s;
  logic ready_s;

  pin_sync #(.W(17)) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    // Ready is carried inverted so the cleared flops read as ready
    .async_in({~op_complete_flag, data_in}),
    .sync_out(sync_v)
  );
  assign data_s = sync_v[15:0];
  assign ready_s = ~sync_v[16];

  always_comb begin
    next_st = st;
    next_st.rd_data = 32'h0000_0000;
    if (st.cnt != 8'h00) begin
      next_st.cnt = st.cnt - 8'h01;
    end
    if (!ready_s) begin
      next_st.busy_seen = 1'b1;
    end
    if (sw.rd) begin
      if (sw.addr == `REG_ADDR) begin
        next_st.rd_data = {10'h000, st.addr};
      end else if (sw.addr == `REG_WDATA) begin
        next_st.rd_data = {16'h0000, st.wdata};
      end else if (sw.addr == `REG_CTRL) begin
        next_st.rd_data = {24'h000000, st.ctrl};
      end else if (sw.addr == `REG_STATUS) begin
        next_st.rd_data = {29'h0, st.busy_seen, ready_s,
          st.phase != ST_IDLE};
        // Clear on read, but a busy pin in the same cycle wins
        next_st.busy_seen = !ready_s;
      end else if (sw.addr == `REG_RDATA) begin
        next_st.rd_data = {16'h0000, st.rdata};
      end
    end
    if (sw.wr) begin
      if (sw.addr == `REG_ADDR) begin
        next_st.addr = sw.wdata[21:0];
      end else if (sw.addr == `REG_WDATA) begin
        next_st.wdata = sw.wdata[15:0];
      end else if (sw.addr == `REG_CTRL) begin
        next_st.ctrl = {sw.wdata[7:2], 2'b00};
      end
    end
    // Level pins follow control one cycle later; accel and wp are independent
    next_st.pins.wide = st.ctrl[`CTRL_WIDE];
    next_st.pins.accel = st.ctrl[`CTRL_ACCEL];
    next_st.pins.wp_n = !st.ctrl[`CTRL_WP];
    case (st.phase)
      ST_IDLE: begin
        next_st.pins.ce_n = 1'b1;
        next_st.pins.oe_n = 1'b1;
        next_st.pins.we_n = 1'b1;
        next_st.drive = 1'b0;
        if (sw.wr && sw.addr == `REG_CTRL && sw.wdata[`CTRL_FLASH_RST]) begin
          next_st.phase = ST_RST_PULSE;
          next_st.cnt = 8'(`RESET_PULSE_CYC);
          next_st.pins.rst_n = 1'b0;
        end else if (sw.wr && sw.addr == `REG_CTRL
                     && sw.wdata[`CTRL_GO_READ]) begin
          next_st.phase = ST_RD_SETUP;
          next_st.pins.addr = st.addr[21:1];
          next_st.pins.byte_lsb = st.addr[0];
        end else if (sw.wr && sw.addr == `REG_CTRL
                     && sw.wdata[`CTRL_GO_WRITE]) begin
          next_st.phase = ST_WR_SETUP;
          next_st.cnt = 8'(`SETUP_CYC);
          next_st.pins.addr = st.addr[21:1];
          next_st.pins.byte_lsb = st.addr[0];
        end
      end
      ST_RD_SETUP: begin
        next_st.pins.ce_n = 1'b0;
        next_st.pins.oe_n = 1'b0;
        next_st.pins.we_n = 1'b1;
        next_st.cnt = 8'(`ACCESS_CYC + 2);
        next_st.phase = ST_RD_WAIT;
      end
      ST_RD_WAIT: begin
        // Two extra cycles cover the pin synchroniser
        if (st.cnt == 8'h00) begin
          next_st.rdata = st.ctrl[`CTRL_WIDE] ? data_s
                                               : {8'h00, data_s[7:0]};
          next_st.pins.ce_n = 1'b1;
          next_st.pins.oe_n = 1'b1;
          next_st.phase = ST_IDLE;
        end
      end
      ST_WR_SETUP: begin
        next_st.pins.ce_n = 1'b0;
        next_st.pins.oe_n = 1'b1;
        next_st.drive = 1'b1;
        if (st.cnt == 8'h00) begin
          next_st.pins.we_n = 1'b0;
          next_st.cnt = 8'(`WRITE_PULSE_CYC - 1);
          next_st.phase = ST_WR_PULSE;
        end
      end
      ST_WR_PULSE: begin
        if (st.cnt == 8'h00) begin
          next_st.pins.we_n = 1'b1;
          next_st.phase = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD: begin
        next_st.pins.ce_n = 1'b1;
        next_st.drive = 1'b0;
        next_st.phase = ST_IDLE;
      end
      ST_RST_PULSE: begin
        if (st.cnt == 8'h00) begin
          next_st.pins.rst_n = 1'b1;
          next_st.cnt = 8'(`RESET_REC_CYC);
          next_st.phase = ST_RST_REC;
        end
      end
      ST_RST_REC: begin
        if (st.cnt == 8'h00) begin
          next_st.phase = ST_IDLE;
        end
      end
      default: begin
        next_st.phase = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st <= '0;
      st.phase <= ST_IDLE;
      st.ctrl <= `CTRL_RESET;
      st.pins.ce_n <= 1'b1;
      st.pins.oe_n <= 1'b1;
      st.pins.we_n <= 1'b1;
      st.pins.rst_n <= 1'b1;
      st.pins.wp_n <= 1'b1;
      st.pins.wide <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign pins = st.pins;
  assign rd_data = st.rd_data;
  // Upper byte lines stay released in byte mode
  assign data_out = st.ctrl[`CTRL_WIDE] ? st.wdata : {8'h00, st.wdata[7:0]};
  assign data_oe_n = st.drive ? (st.ctrl[`CTRL_WIDE] ? 16'h0000 : 16'hFF00)
                              : 16'hFFFF;

  a_read_no_we: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !st.pins.oe_n |-> st.pins.we_n && !st.pins.ce_n && !st.drive)
    else $error("read cycle with write strobe or drive");
  a_write_gate_hi: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !st.pins.we_n |-> st.pins.oe_n && !st.pins.ce_n && st.drive)
    else $error("write strobe without gate high");
  sequence s_we_fall;
    $fell(st.pins.we_n);
  endsequence
  a_we_width: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_we_fall |-> !st.pins.we_n [*4] ##1 st.pins.we_n)
    else $error("write pulse width wrong");
  a_read_access: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(st.pins.oe_n) |-> !st.pins.oe_n [*8] ##1 !st.pins.oe_n)
    else $error("read gate released early");
  a_rst_width: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(st.pins.rst_n) |-> !st.pins.rst_n [*8])
    else $error("reset pulse too short");
  a_rst_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !st.pins.rst_n |-> st.pins.ce_n && st.pins.we_n)
    else $error("cycle during flash reset");
  a_wide_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ##1 st.pins.wide == $past(st.ctrl[`CTRL_WIDE]))
    else $error("width pin not following control");
  a_byte_float: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !st.ctrl[`CTRL_WIDE] |-> data_oe_n[15:8] == 8'hFF)
    else $error("upper lines driven in byte mode");
endmodule
`default_nettype wire

// ---- design/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] first;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      first <= '0;
      sync_out <= '0;
    end else begin
      first <= async_in;
      sync_out <= first;
    end
  end
endmodule
`default_nettype wire
